// [lil_loader.sv]
/*
 Location input loader: Avalon-MM register slave, reference coordinate
 and measured parameter slot storage, start pulse and completion flag.
 Assumes a single 100 MHz clock and a synchronous Avalon-MM master.
*/
// The Avalon-MM slave port and the address map were decided locally.
`timescale 1ns/1ps
`default_nettype none
module lil_loader (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rstn,
    // avalon-mm slave
    input wire logic [lil_pkg::LIL_ADDR_W-1:0] i_address,
    input wire logic i_read,
    input wire logic i_write,
    input wire logic [31:0] i_writedata,
    output logic [31:0] o_readdata,
    output logic o_waitrequest,
    // estimation datapath
    output lil_pkg::lil_inputs_t o_inputs,
    output logic o_engine_en,
    output logic o_start,
    output logic o_done
);
    import lil_pkg::*;

    lil_state_t q;
    lil_state_t d;
    logic [7:0] lut_val;
    logic req;
    logic take;
    logic [7:0] wd;
    logic [3:0] rssi_slot;

    function automatic logic hit(input logic [LIL_ADDR_W-1:0] addr, input logic [7:0] idx);
        hit = (addr[LIL_ADDR_W-1:2] == idx) && (addr[1:0] == LIL_LANE0);
    endfunction : hit

    lil_exp_lut u_lut (
        .i_idx(wd[4:0]),
        .o_val(lut_val)
    );

    assign req = i_read | i_write;
    assign take = req & ~q.stall;
    assign wd = i_writedata[7:0];
    assign rssi_slot = q.par_ptr - LIL_PAR_RSSI0;

    always_comb begin
        d = q;
        d.start = 1'b0;
        // one wait cycle per access, then the answer
        d.stall = ~(req & q.stall);
        if (req & q.stall) begin
            d.rdata = '0;
            if (hit(i_address, LIL_IDX_CTRL)) begin
                d.rdata[LIL_BIT_EN] = q.en;
                d.rdata[LIL_BIT_DONE] = q.done;
                d.rdata[LIL_BIT_PARAM_LOAD_FLAG] = q.param_load_flag;
                d.rdata[LIL_BIT_REF_LOAD_FLAG] = q.ref_load_flag;
            end else if (hit(i_address, LIL_IDX_REFPOS)) begin
                d.rdata[7:0] = q.ref_last;
            end else if (hit(i_address, LIL_IDX_MEAS)) begin
                d.rdata[7:0] = q.par_last;
            end
        end
        if (q.en && (q.cnt != LIL_CNT_IDLE)) begin
            d.cnt = q.cnt - LIL_CNT_LAST;
            if (q.cnt == LIL_CNT_LAST) begin
                d.done = 1'b1;
            end
        end
        if (take & i_write) begin
            if (hit(i_address, LIL_IDX_CTRL)) begin
                d.en = wd[LIL_BIT_EN];
                d.ref_load_flag = wd[LIL_BIT_REF_LOAD_FLAG];
                d.param_load_flag = wd[LIL_BIT_PARAM_LOAD_FLAG];
                if (wd[LIL_BIT_REF_LOAD_FLAG] && !q.ref_load_flag) begin
                    d.ref_ptr = LIL_PTR_FIRST;
                end
                if (wd[LIL_BIT_PARAM_LOAD_FLAG] && !q.param_load_flag) begin
                    d.par_ptr = LIL_PTR_FIRST;
                end
                if (wd[LIL_BIT_RUN] && wd[LIL_BIT_EN]) begin
                    d.start = 1'b1;
                    d.done = 1'b0;
                    d.cnt = LIL_RESULT_CYCLES;
                end
            end else if (hit(i_address, LIL_IDX_REFPOS)) begin
                d.ref_last = wd;
                if (q.ref_load_flag) begin
                    d.inp.coord[q.ref_ptr] = wd;
                    d.ref_ptr = q.ref_ptr + LIL_PTR_STEP;
                end
            end else if (hit(i_address, LIL_IDX_MEAS)) begin
                d.par_last = wd;
                // extra writes past ten dropped too
                if (q.param_load_flag && (q.par_ptr < LIL_N_PARAM)) begin
                    if (q.par_ptr == LIL_PAR_A) begin
                        d.inp.ref_power = wd;
                    end else if (q.par_ptr == LIL_PAR_N) begin
                        d.inp.exp_idx = wd[4:0];
                        d.inp.exp_val = lut_val;
                    end else begin
                        d.inp.rssi[rssi_slot[2:0]] = wd;
                    end
                    d.par_ptr = q.par_ptr + LIL_PTR_STEP;
                end
            end
        end
        d.inp.act_cnt = '0;
        for (int i = 0; i < LIL_N_REF; i++) begin
            d.inp.active[i] = (q.inp.rssi[i] != LIL_RSSI_UNUSED);
            d.inp.act_cnt = d.inp.act_cnt + {3'h0, q.inp.active[i]};
        end
        d.inp.count_ok = (q.inp.act_cnt >= LIL_MIN_ACTIVE) && (q.inp.act_cnt <= LIL_MAX_ACTIVE);
        d.inp.power_ok = (q.inp.ref_power >= LIL_A_MIN) && (q.inp.ref_power <= LIL_A_MAX);
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            q <= '0;
            q.stall <= 1'b1;
            q.inp.exp_val <= LIL_EXP_TABLE[0];
        end else begin
            q <= d;
        end
    end

    assign o_readdata = q.rdata;
    assign o_waitrequest = q.stall;
    assign o_inputs = q.inp;
    assign o_engine_en = q.en;
    assign o_start = q.start;
    assign o_done = q.done;

    logic wr_ref;
    logic wr_meas;
    logic wr_ctrl;
    assign wr_ref = take & i_write & hit(i_address, LIL_IDX_REFPOS);
    assign wr_meas = take & i_write & hit(i_address, LIL_IDX_MEAS);
    assign wr_ctrl = take & i_write & hit(i_address, LIL_IDX_CTRL);

    AST_COORD_FILL: assert property (@(posedge i_clk) disable iff (!i_rstn)
        wr_ref && q.ref_load_flag |=> q.inp.coord[$past(q.ref_ptr)] == $past(wd) && q.ref_ptr == $past(q.ref_ptr) + 4'h1)
        else $error("coordinate byte not stored in its slot");
    AST_IGNORE: assert property (@(posedge i_clk) disable iff (!i_rstn)
        wr_ref && !q.ref_load_flag |=> $stable(q.inp.coord) && $stable(q.ref_ptr))
        else $error("coordinate write outside load changed slots");
    AST_PTR_RESET: assert property (@(posedge i_clk) disable iff (!i_rstn)
        wr_ctrl && wd[LIL_BIT_REF_LOAD_FLAG] && !q.ref_load_flag |=> q.ref_ptr == 4'h0 && q.ref_load_flag)
        else $error("reference pointer not reset on load start");
    AST_PARAM_ORDER: assert property (@(posedge i_clk) disable iff (!i_rstn)
        wr_meas && q.param_load_flag && q.par_ptr == 4'h0 |=> q.inp.ref_power == $past(wd) && q.par_ptr == 4'h1)
        else $error("first parameter not taken as reference power");
    AST_EXP_MAP: assert property (@(posedge i_clk) disable iff (!i_rstn)
        q.inp.exp_idx == 5'h0D |-> q.inp.exp_val == 8'h18)
        else $error("exponent index 13 not mapped to 3.000");
    AST_EXP_LOW: assert property (@(posedge i_clk) disable iff (!i_rstn)
        wr_meas && q.param_load_flag && q.par_ptr == 4'h1 |=> q.inp.exp_idx == $past(wd[4:0]))
        else $error("exponent index not taken from low bits");
    AST_UNUSED: assert property (@(posedge i_clk) disable iff (!i_rstn)
        q.inp.rssi[0] == 8'h00 ##1 q.inp.rssi[0] == 8'h00 |=> !q.inp.active[0])
        else $error("zero strength slot reported active");
    AST_COUNT: assert property (@(posedge i_clk) disable iff (!i_rstn)
        q.inp.count_ok |-> $past(q.inp.act_cnt) inside {[4'h3:4'h8]})
        else $error("active count window wrong");
    AST_POWER: assert property (@(posedge i_clk) disable iff (!i_rstn)
        q.inp.power_ok |-> $past(q.inp.ref_power) >= 8'h3C && $past(q.inp.ref_power) <= 8'h64)
        else $error("reference power window wrong");
    AST_DONE_CLR: assert property (@(posedge i_clk) disable iff (!i_rstn)
        q.start |-> !q.done && q.cnt == LIL_RESULT_CYCLES)
        else $error("start did not clear done and load count");
    AST_DONE_SET: assert property (@(posedge i_clk) disable iff (!i_rstn)
        q.en && q.cnt == 11'h001 && !wr_ctrl |=> q.done && q.cnt == 11'h000)
        else $error("done not set at end of count");

    COV_REF_LOAD: cover property (@(posedge i_clk) disable iff (!i_rstn)
        wr_ref && q.ref_load_flag && q.ref_ptr == 4'hF);
    COV_PARAM_LOAD: cover property (@(posedge i_clk) disable iff (!i_rstn)
        wr_meas && q.param_load_flag && q.par_ptr == 4'h9);
    COV_DONE: cover property (@(posedge i_clk) disable iff (!i_rstn) $rose(q.done));
    COV_COUNT_OK: cover property (@(posedge i_clk) disable iff (!i_rstn) $rose(q.inp.count_ok));
endmodule : lil_loader
`default_nettype wire

// [lil_pkg.sv]
/*
 Shared constants and types for the location input loader.
 Assumes a 100 MHz system clock and an Avalon-MM master with 32-bit data.
*/
package lil_pkg;
    // register indices; byte address is four times the index
    localparam logic [7:0] LIL_IDX_REFPOS = 8'h55;
    localparam logic [7:0] LIL_IDX_MEAS = 8'h56;
    localparam logic [7:0] LIL_IDX_CTRL = 8'h57;
    localparam int LIL_ADDR_W = 10;
    localparam logic [1:0] LIL_LANE0 = 2'h0;

    // engine_ctrl_status bit positions
    localparam int LIL_BIT_EN = 4;
    localparam int LIL_BIT_DONE = 3;
    localparam int LIL_BIT_PARAM_LOAD_FLAG = 2;
    localparam int LIL_BIT_REF_LOAD_FLAG = 1;
    localparam int LIL_BIT_RUN = 0;

    localparam int LIL_N_REF = 8;
    localparam int LIL_N_COORD = 16;
    localparam logic [3:0] LIL_PTR_FIRST = 4'h0;
    localparam logic [3:0] LIL_PTR_STEP = 4'h1;
    localparam logic [3:0] LIL_N_PARAM = 4'hA;
    localparam logic [3:0] LIL_PAR_A = 4'h0;
    localparam logic [3:0] LIL_PAR_N = 4'h1;
    localparam logic [3:0] LIL_PAR_RSSI0 = 4'h2;

    // completion latency in system clock cycles
    localparam int LIL_RESULT_CYCLES_INT = 1200;
    localparam int LIL_CNT_W = 11;
    localparam logic [LIL_CNT_W-1:0] LIL_RESULT_CYCLES = LIL_CNT_W'(LIL_RESULT_CYCLES_INT);
    localparam logic [LIL_CNT_W-1:0] LIL_CNT_LAST = 11'h001;
    localparam logic [LIL_CNT_W-1:0] LIL_CNT_IDLE = 11'h000;

    // active reference count window
    localparam logic [3:0] LIL_MIN_ACTIVE = 4'h3;
    localparam logic [3:0] LIL_MAX_ACTIVE = 4'h8;
    // reference power window in half units: 30.0 .. 50.0
    localparam logic [7:0] LIL_A_MIN = 8'h3C;
    localparam logic [7:0] LIL_A_MAX = 8'h64;
    localparam logic [7:0] LIL_RSSI_UNUSED = 8'h00;

    // exponent table, value has three fractional bits, entry 31 first
    localparam logic [31:0][7:0] LIL_EXP_TABLE = {
        8'h40, 8'h38, 8'h30, 8'h2C, 8'h28, 8'h25, 8'h24, 8'h23,
        8'h22, 8'h21, 8'h20, 8'h1F, 8'h1E, 8'h1D, 8'h1C, 8'h1B,
        8'h1A, 8'h19, 8'h18, 8'h17, 8'h16, 8'h15, 8'h14, 8'h13,
        8'h12, 8'h11, 8'h10, 8'h0F, 8'h0E, 8'h0C, 8'h0A, 8'h08};

    // coordinate: 6 integer bits, 2 fractional bits
    typedef logic [7:0] lil_coord_t;
    // reference power and signal strength: LSB is a half unit
    typedef logic [7:0] lil_half_t;

    typedef struct packed {
        logic [LIL_N_COORD-1:0][7:0] coord;
        logic [LIL_N_REF-1:0][7:0] rssi;
        lil_half_t ref_power;
        logic [4:0] exp_idx;
        logic [7:0] exp_val;
        logic [LIL_N_REF-1:0] active;
        logic [3:0] act_cnt;
        logic count_ok;
        logic power_ok;
    } lil_inputs_t;

    typedef struct packed {
        logic stall;
        logic [31:0] rdata;
        logic en;
        logic ref_load_flag;
        logic param_load_flag;
        logic done;
        logic start;
        logic [LIL_CNT_W-1:0] cnt;
        logic [3:0] ref_ptr;
        logic [3:0] par_ptr;
        logic [7:0] ref_last;
        logic [7:0] par_last;
        lil_inputs_t inp;
    } lil_state_t;
endpackage : lil_pkg

// [lil_exp_lut.sv]
/*
 Path-loss exponent lookup: index to fixed-point exponent value.
 Assumes the caller registers the result.
*/
`timescale 1ns/1ps
`default_nettype none
module lil_exp_lut (
    // index in, value out
    input wire logic [4:0] i_idx,
    output logic [7:0] o_val
);
    import lil_pkg::*;

    always_comb begin
        o_val = LIL_EXP_TABLE[i_idx];
    end
endmodule : lil_exp_lut
`default_nettype wire

// [lil_loader_tb.sv]
/*
 Self-checking bench for lil_loader: Avalon tasks, slot model, checks.
 Assumes one wait cycle per access and the package register indices.
*/
`timescale 1ns/1ps
`default_nettype none
module lil_loader_tb;
    import lil_pkg::*;
    logic i_clk = 1'b0;
    logic i_rstn = 1'b0;
    logic [LIL_ADDR_W-1:0] i_address = '0;
    logic i_read = 1'b0;
    logic i_write = 1'b0;
    logic [31:0] i_writedata = '0;
    logic [31:0] o_readdata;
    logic o_waitrequest;
    lil_inputs_t o_inputs;
    logic o_engine_en;
    logic o_start;
    logic o_done;
    int n_errors = 0;
    int samples_checked = 0;
    logic [15:0] lfsr = 16'h1C24;
    logic [7:0] mc[16];
    logic [7:0] mr[8];
    logic [31:0] q;

    lil_loader u_lil_loader (.i_clk(i_clk), .i_rstn(i_rstn), .i_address(i_address), .i_read(i_read),
        .i_write(i_write), .i_writedata(i_writedata), .o_readdata(o_readdata),
        .o_waitrequest(o_waitrequest), .o_inputs(o_inputs), .o_engine_en(o_engine_en),
        .o_start(o_start), .o_done(o_done));

    initial begin
        forever #5 i_clk = ~i_clk;
    end

    // exponent value in eighths
    function automatic logic [7:0] exp_of(input int i);
        if (i < 4) return 8'(8 + 2 * i);
        if (i < 27) return 8'(i + 11);
        return (i == 27) ? 8'h28 : (i == 28) ? 8'h2C : (i == 29) ? 8'h30 : (i == 30) ? 8'h38 : 8'h40;
    endfunction : exp_of

    function automatic logic [7:0] rnd();
        lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
        return lfsr[7:0];
    endfunction : rnd

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    // hold request until waitrequest sampled low
    task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] d);
        int t;
        @(posedge i_clk);
        i_address <= {idx, 2'b00};
        i_write <= wr;
        i_read <= ~wr;
        i_writedata <= {24'h0, d};
        t = 0;
        do begin
            @(posedge i_clk);
            t++;
        end while (o_waitrequest !== 1'b0 && t < 50);
        q = o_readdata;
        i_write <= 1'b0;
        i_read <= 1'b0;
        if (t >= 50) n_errors++;
    endtask : bus

    task automatic do_reset();
        i_rstn <= 1'b0;
        repeat (8) @(posedge i_clk);
        chk(o_waitrequest, 1);
        chk(o_readdata, 0);
        chk(o_inputs.exp_val, 8'h08);
        chk({o_done, o_engine_en, o_start, o_inputs.coord[0], o_inputs.rssi[0]}, 0);
        i_rstn <= 1'b1;
    endtask : do_reset

    task automatic print_verdict();
        if (n_errors == 0 && samples_checked > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : print_verdict

    initial begin
        #100000;
        n_errors++;
        print_verdict();
    end

    initial begin : main
        logic [7:0] r;
        logic [7:0] a;
        logic [7:0] act;
        int cnt;
        int t;
        int t0;
        do_reset();
        // aborted partial load; next rise must restart at slot 0
        bus(1, LIL_IDX_CTRL, 8'h12);
        repeat (3) bus(1, LIL_IDX_REFPOS, 8'hEE);
        bus(1, LIL_IDX_CTRL, 8'h10);
        bus(1, LIL_IDX_CTRL, 8'h12);
        chk(o_engine_en, 1);
        for (int k = 0; k < 16; k++) begin
            mc[k] = rnd();
            bus(1, LIL_IDX_REFPOS, mc[k]);
        end
        bus(1, LIL_IDX_CTRL, 8'h10);
        for (int k = 0; k < 16; k++) chk(o_inputs.coord[k], mc[k]);
        // write with flag low leaves slots alone
        bus(1, LIL_IDX_REFPOS, ~mc[0]);
        bus(0, LIL_IDX_REFPOS, 8'h00);
        chk(q, {24'h0, ~mc[0]});
        chk(o_inputs.coord[0], mc[0]);
        for (int i = 0; i < 32; i++) begin
            r = rnd();
            a = (i == 0) ? 8'd59 : (i == 1) ? 8'd60 : (i == 2) ? 8'd100 : (i == 3) ? 8'd101 : 8'(60 + r % 41);
            cnt = i % 9;
            bus(1, LIL_IDX_CTRL, 8'h14);
            bus(1, LIL_IDX_MEAS, a);
            bus(1, LIL_IDX_MEAS, 8'(i));
            act = 8'h00;
            for (int k = 0; k < 8; k++) begin
                r = rnd();
                // magnitude 40..95 dB in half units
                mr[k] = (k < cnt) ? 8'(80 + r % 111) : LIL_RSSI_UNUSED;
                act[k] = (k < cnt);
                bus(1, LIL_IDX_MEAS, mr[k]);
            end
            bus(0, LIL_IDX_MEAS, 8'h00);
            chk(q, {24'h0, mr[7]});
            // an eleventh value is past the set and ignored
            bus(1, LIL_IDX_MEAS, 8'h00);
            bus(1, LIL_IDX_CTRL, 8'h10);
            repeat (4) @(posedge i_clk);
            chk(o_inputs.ref_power, a);
            chk(o_inputs.power_ok, (a >= 60 && a <= 100));
            chk(o_inputs.exp_idx, i);
            chk(o_inputs.exp_val, exp_of(i));
            for (int k = 0; k < 8; k++) chk(o_inputs.rssi[k], mr[k]);
            chk(o_inputs.active, act);
            chk(o_inputs.act_cnt, cnt);
            chk(o_inputs.count_ok, (cnt >= 3));
        end
        // run: done cleared with start, set 1200 cycles on
        bus(1, LIL_IDX_CTRL, 8'h11);
        t = 0;
        t0 = 0;
        while (o_done !== 1'b1 && t < 1300) begin
            @(posedge i_clk);
            t++;
            if (o_start === 1'b1) begin
                t0 = t;
                chk(o_done, 0);
            end
        end
        chk(t0, 1);
        chk(t - t0, LIL_RESULT_CYCLES_INT);
        bus(0, LIL_IDX_CTRL, 8'h00);
        chk(q, 32'h18);
        // run without enable is ignored
        bus(1, LIL_IDX_CTRL, 8'h01);
        repeat (2) @(posedge i_clk);
        chk({o_start, o_done, o_engine_en}, 3'b010);
        bus(0, 8'h58, 8'h00);
        chk(q, 0);
        bus(1, 8'h58, 8'hFF);
        bus(0, LIL_IDX_CTRL, 8'h00);
        chk(q, 32'h08);
        // a second run clears the done flag left by the first
        bus(1, LIL_IDX_CTRL, 8'h11);
        @(posedge i_clk);
        chk({o_start, o_done}, 2'b10);
        // reset in mid-count, then the bus must answer again
        do_reset();
        bus(0, LIL_IDX_CTRL, 8'h00);
        chk(q, 0);
        print_verdict();
    end
endmodule : lil_loader_tb
`default_nettype wire
